// ===== rtl/timer_irq_load.sv
// Timer interrupt status/clear and interval load registers on AXI4-Lite.
//
// Overview of operation
// - Writing one to a clear bit clears raw and masked status bits.
// - The A interval load holds the start count loaded into the counter.
// - In 32-bit mode the A load upper half reads the B load value.
// - In 16-bit mode the upper half reads zero and never alters B load.
// - Writing the A load lower half loads the A counter in both modes.
// - A load resets to all ones; upper half zero in 16-bit mode.
`timescale 1ns/1ps
`default_nettype none

module timer_irq_load #(
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   // AXI4-Lite write address channel.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   // AXI4-Lite write data channel.
   input  wire logic [31:0]       s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   // AXI4-Lite write response channel.
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   // AXI4-Lite read address channel.
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   // AXI4-Lite read data channel.
   output logic [31:0]            s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   // Timer events, one-cycle pulses from the counting logic.
   input  wire logic [6:0]        irq_event_in,
   // Interrupt and configuration towards the rest of the timer.
   output logic                   irq_out,
   output logic                   split_mode_out,
   // Load values and the A counter load strobe.
   output logic [31:0]            a_load_value_out,
   output logic                   a_counter_load_out,
   output logic [15:0]            b_load_value_out
);

   // Write channel state and captured halves of a write.
   timer_pkg::wr_state_t wr_state_q;
   timer_pkg::wr_state_t wr_state_d;
   logic              aw_got_q;
   logic              aw_got_d;
   logic              w_got_q;
   logic              w_got_d;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic              bvalid_d;
   logic [1:0]        bresp_q;

   // Read channel registers.
   logic              arready_q;
   logic              rvalid_q;
   logic              rvalid_d;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;

   // Software-visible state.
   logic              split_q;
   logic              split_d;
   logic [31:0]       enable_q;
   logic [31:0]       enable_d;
   logic [15:0]       a_low_q;
   logic [15:0]       a_low_d;
   logic [15:0]       b_load_q;
   logic [15:0]       b_load_d;
   logic [31:0]       a_value_q;
   logic              a_load_pulse_q;
   logic              irq_q;

   // Status flags held in the sticky bank.
   logic [31:0]       raw_status;
   logic [31:0]       masked_status;
   logic [31:0]       irq_set;
   logic [31:0]       irq_clear;

   // Word offset of a byte address; the bus may carry any low two bits,
   // and both the write and the read decode must ignore them alike.
   function automatic logic [11:0] word_off(input logic [ADDR_W-1:0] a);
      return {a[11:2], 2'b00};
   endfunction

   // Handshakes and the merged write request.
   // A half counts as present when it is parked or offered right now, so
   // a write whose halves arrive together completes in a single edge.
   wire aw_hs = s_axi_awvalid_in & awready_q;
   wire w_hs  = s_axi_wvalid_in & wready_q;
   wire aw_have = aw_got_q | aw_hs;
   wire w_have  = w_got_q | w_hs;
   wire do_write = (wr_state_q == timer_pkg::WR_COLLECT)
                   & aw_have & w_have;

   // Address and data come from the holding flops or straight from the bus.
   wire [ADDR_W-1:0] wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr_in;
   wire [31:0]       wr_data = w_got_q ? w_data_q : s_axi_wdata_in;
   wire [3:0]        wr_strb = w_got_q ? w_strb_q : s_axi_wstrb_in;
   wire [31:0]       wr_bits = timer_pkg::strb_mask(wr_strb);

   // Word address of the write, low two bits ignored.
   wire [11:0] wr_off = word_off(wr_addr);

   // Write decode.
   wire wr_cfg    = do_write & (wr_off == timer_pkg::WIDTH_CONFIG_OFF);
   wire wr_enable = do_write & (wr_off == timer_pkg::IRQ_ENABLE_OFF);
   wire wr_raw    = do_write & (wr_off == timer_pkg::RAW_STATUS_OFF);
   wire wr_masked = do_write & (wr_off == timer_pkg::MASKED_STATUS_OFF);
   wire wr_clear  = do_write & (wr_off == timer_pkg::IRQ_CLEAR_OFF);
   wire wr_a_load = do_write & (wr_off == timer_pkg::A_LOAD_OFF);
   wire wr_b_load = do_write & (wr_off == timer_pkg::B_LOAD_OFF);
   wire wr_mapped = wr_cfg | wr_enable | wr_raw | wr_masked
                    | wr_clear | wr_a_load | wr_b_load;

   // Write channel sequencing: gather both halves, answer, then reopen.
   // The registers move on the same edge that raises bvalid, so a read
   // issued after the response always sees the new contents.
   // Both readies stay low until the response is taken; that is what
   // keeps a second write from overtaking the answer of the first.
   assign aw_got_d = do_write ? 1'b0 : aw_have;
   assign w_got_d  = do_write ? 1'b0 : w_have;
   assign wr_state_d = do_write ? timer_pkg::WR_RESP :
                       (bvalid_q & s_axi_bready_in) ?
                       timer_pkg::WR_COLLECT : wr_state_q;
   assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready_in);

   // Write channel flops.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_state_q <= timer_pkg::WR_COLLECT;
         aw_got_q   <= 1'b0;
         w_got_q    <= 1'b0;
         awready_q  <= 1'b0;
         wready_q   <= 1'b0;
         bvalid_q   <= 1'b0;
      end else begin
         wr_state_q <= wr_state_d;
         aw_got_q   <= aw_got_d;
         w_got_q    <= w_got_d;
         awready_q  <= (wr_state_d == timer_pkg::WR_COLLECT) & ~aw_got_d;
         wready_q   <= (wr_state_d == timer_pkg::WR_COLLECT) & ~w_got_d;
         bvalid_q   <= bvalid_d;
      end
   end

   // Holding flops for a half that arrives before its partner.
   // Only the handshake loads them, so a master that changes its payload
   // after the handshake cannot corrupt a parked half.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aw_addr_q <= '0;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bresp_q   <= timer_pkg::RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (w_hs) begin
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end
         if (do_write) begin
            bresp_q <= wr_mapped ? timer_pkg::RESP_OKAY :
                       timer_pkg::RESP_SLVERR;
         end
      end
   end

   // Width configuration; a change of mode keeps the stored B load value.
   assign split_d = wr_cfg & wr_strb[0] ?
                    wr_data[timer_pkg::SPLIT_MODE_BIT] : split_q;

   // Only implemented bits can be enabled.
   assign enable_d = wr_enable ?
                     (((wr_data & wr_bits) | (enable_q & ~wr_bits))
                      & timer_pkg::IRQ_IMPL_MASK) : enable_q;

   // Lower half of the A load is written in both modes.
   assign a_low_d = wr_a_load ?
                    ((wr_data[15:0] & wr_bits[15:0])
                     | (a_low_q & ~wr_bits[15:0])) : a_low_q;

   // The A load upper half writes B only in 32-bit mode; the B register
   // itself is written directly only in 16-bit mode.
   // Direct B writes in 32-bit mode are answered OKAY and dropped, since
   // the B register then belongs to the upper half of the A load.
   assign b_load_d =
      (wr_a_load & ~split_q) ?
         ((wr_data[31:16] & wr_bits[31:16])
          | (b_load_q & ~wr_bits[31:16])) :
      (wr_b_load & split_q) ?
         ((wr_data[15:0] & wr_bits[15:0])
          | (b_load_q & ~wr_bits[15:0])) : b_load_q;

   // The full A load as seen by the counter and by software.
   wire [15:0] a_upper_d = split_d ?
                           timer_pkg::UPPER_SPLIT_VAL : b_load_d;
   wire [15:0] a_upper_q = split_q ?
                           timer_pkg::UPPER_SPLIT_VAL : b_load_q;

   // A counter reload fires on any write touching the lower half.
   // A write that strobes only the upper lanes leaves the count alone.
   wire a_load_fire = wr_a_load & (|wr_strb[1:0]);

   // Configuration and load registers, with all-ones load reset.
   // The width select leaves reset in 32-bit mode, which is why the
   // upper half of the A load starts at all ones and not at zero.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         split_q        <= timer_pkg::SPLIT_RESET;
         enable_q       <= timer_pkg::ENABLE_RESET;
         a_low_q        <= timer_pkg::LOAD_RESET;
         b_load_q       <= timer_pkg::LOAD_RESET;
         a_value_q      <= {timer_pkg::LOAD_RESET,
                            timer_pkg::LOAD_RESET};
         a_load_pulse_q <= 1'b0;
      end else begin
         split_q        <= split_d;
         enable_q       <= enable_d;
         a_low_q        <= a_low_d;
         b_load_q       <= b_load_d;
         a_value_q      <= {a_upper_d, a_low_d};
         a_load_pulse_q <= a_load_fire;
      end
   end

   // Events set status; the clear register takes ones only on implemented
   // bits, zeros and reserved positions do nothing.
   // The clear is masked here, so a write of all ones cannot disturb
   // reserved status positions that a later revision might use.
   assign irq_set   = timer_pkg::irq_expand(irq_event_in);
   assign irq_clear = wr_clear ?
                      (wr_data & wr_bits & timer_pkg::IRQ_IMPL_MASK) :
                      32'h00000000;

   // Sticky status; a masked bit is the raw bit gated by its enable, so
   // clearing the raw bit clears the masked view in the same edge.
   irq_sticky_bank #(
      .WIDTH (32)
   ) u_status (
      .clock_in   (clock_in),
      .resetn_in  (resetn_in),
      .set_in     (irq_set),
      .clear_in   (irq_clear),
      .status_out (raw_status)
   );

   assign masked_status = raw_status & enable_q;

   // Level interrupt, one flop behind the status it reflects.
   // Limitation: the line drops one cycle after the clearing write is
   // answered, so a handler must not sample it in that cycle.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(raw_status & enable_q);
      end
   end

   // Read decode; the clear register is write-only and reads zero.
   // Reading never disturbs status: a read of the clear register is a
   // plain zero, not a read-to-clear, so a debugger cannot lose events.
   wire [11:0] rd_off = word_off(s_axi_araddr_in);
   wire rd_cfg    = rd_off == timer_pkg::WIDTH_CONFIG_OFF;
   wire rd_enable = rd_off == timer_pkg::IRQ_ENABLE_OFF;
   wire rd_raw    = rd_off == timer_pkg::RAW_STATUS_OFF;
   wire rd_masked = rd_off == timer_pkg::MASKED_STATUS_OFF;
   wire rd_clear  = rd_off == timer_pkg::IRQ_CLEAR_OFF;
   wire rd_a_load = rd_off == timer_pkg::A_LOAD_OFF;
   wire rd_b_load = rd_off == timer_pkg::B_LOAD_OFF;
   wire rd_mapped = rd_cfg | rd_enable | rd_raw | rd_masked
                    | rd_clear | rd_a_load | rd_b_load;

   // Read data selection; unlisted registers return zero.
   wire [31:0] rd_word =
      rd_cfg    ? {31'h00000000, split_q} :
      rd_enable ? enable_q :
      rd_raw    ? raw_status :
      rd_masked ? masked_status :
      rd_a_load ? {a_upper_q, a_low_q} :
      rd_b_load ? {16'h0000, b_load_q} :
      32'h00000000;

   // Read handshake.
   wire ar_hs = s_axi_arvalid_in & arready_q;
   assign rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready_in);

   // Read channel flops; one read is served at a time.
   // Read data are captured at the address handshake and then stand
   // while rvalid waits for rready; an event in that time shows up on
   // the next read, never as a change of a pending answer.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= timer_pkg::RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q  <= rvalid_d;
         if (ar_hs) begin
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? timer_pkg::RESP_OKAY :
                       timer_pkg::RESP_SLVERR;
         end
      end
   end

   // Port drivers, all from flops.
   // No output passes through logic, so the timer sees clean edges.
   assign s_axi_awready_out  = awready_q;
   assign s_axi_wready_out   = wready_q;
   assign s_axi_bvalid_out   = bvalid_q;
   assign s_axi_bresp_out    = bresp_q;
   assign s_axi_arready_out  = arready_q;
   assign s_axi_rvalid_out   = rvalid_q;
   assign s_axi_rdata_out    = rdata_q;
   assign s_axi_rresp_out    = rresp_q;
   assign irq_out            = irq_q;
   assign split_mode_out     = split_q;
   assign a_load_value_out   = a_value_q;
   assign a_counter_load_out = a_load_pulse_q;
   assign b_load_value_out   = b_load_q;

endmodule

`default_nettype wire

// ===== rtl/timer_pkg.sv
// Register map, field layout and bus codes of the timer interrupt/load block.
`default_nettype none

package timer_pkg;

   // Register byte offsets.
   localparam logic [11:0] WIDTH_CONFIG_OFF  = 12'h000;
   localparam logic [11:0] IRQ_ENABLE_OFF    = 12'h018;
   localparam logic [11:0] RAW_STATUS_OFF    = 12'h01c;
   localparam logic [11:0] MASKED_STATUS_OFF = 12'h020;
   localparam logic [11:0] IRQ_CLEAR_OFF     = 12'h024;
   localparam logic [11:0] A_LOAD_OFF        = 12'h028;
   localparam logic [11:0] B_LOAD_OFF        = 12'h02c;

   // Interrupt bit positions, shared by status, enable and clear.
   localparam int CLR_A_TIMEOUT_BIT  = 0;
   localparam int CLR_CAPA_MATCH_BIT = 1;
   localparam int CLR_CAPA_EVENT_BIT = 2;
   localparam int CLR_RTC_EVENT_BIT  = 3;
   localparam int CLR_B_TIMEOUT_BIT  = 8;
   localparam int CLR_CAPB_MATCH_BIT = 9;
   localparam int CLR_CAPB_EVENT_BIT = 10;
   localparam int EVENT_COUNT        = 7;

   // Implemented interrupt bits; all others read as zero.
   localparam logic [31:0] IRQ_IMPL_MASK = 32'h0000070f;

   // Width configuration field: set selects two 16-bit timers.
   localparam int SPLIT_MODE_BIT = 0;

   // Reset values.
   localparam logic        SPLIT_RESET     = 1'h0;
   localparam logic [15:0] LOAD_RESET      = 16'hffff;
   localparam logic [15:0] UPPER_SPLIT_VAL = 16'h0000;
   localparam logic [31:0] ENABLE_RESET    = 32'h00000000;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Write channel states.
   typedef enum logic {
      WR_COLLECT = 1'b0,
      WR_RESP    = 1'b1
   } wr_state_t;

   // Spreads the event inputs onto their status bit positions.
   function automatic logic [31:0] irq_expand(
      input logic [EVENT_COUNT-1:0] ev
   );
      logic [31:0] v;
      v = 32'h00000000;
      v[CLR_A_TIMEOUT_BIT]  = ev[0];
      v[CLR_CAPA_MATCH_BIT] = ev[1];
      v[CLR_CAPA_EVENT_BIT] = ev[2];
      v[CLR_RTC_EVENT_BIT]  = ev[3];
      v[CLR_B_TIMEOUT_BIT]  = ev[4];
      v[CLR_CAPB_MATCH_BIT] = ev[5];
      v[CLR_CAPB_EVENT_BIT] = ev[6];
      return v;
   endfunction

   // Turns byte strobes into a bit mask.
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

endpackage

`default_nettype wire

// ===== rtl/irq_sticky_bank.sv
// Bank of sticky status flags, each set by an event and cleared by software.
`timescale 1ns/1ps
`default_nettype none

module irq_sticky_bank #(
   parameter int WIDTH = 32
) (
   // Clock and reset.
   input  wire logic             clock_in,
   input  wire logic             resetn_in,
   // Set and clear requests, one bit per flag.
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   // Flag state.
   output logic      [WIDTH-1:0] status_out
);

   genvar i;

   // One flop per flag; a set in the clearing cycle wins so no event is lost.
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
               status_out[i] <= 1'b0;
            end else if (set_in[i]) begin
               status_out[i] <= 1'b1;
            end else if (clear_in[i]) begin
               status_out[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ===== tb/timer_irq_load_assertions.sv
// Port-level concurrent checks for the timer interrupt and load block.
`timescale 1ns/1ps
`default_nettype none
module timer_irq_load_assertions (
   // Clock and reset.
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   // Bus handshakes and answers.
   input  wire logic        s_axi_awready_out,
   input  wire logic        s_axi_wready_out,
   input  wire logic [1:0]  s_axi_bresp_out,
   input  wire logic        s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic        s_axi_arvalid_in,
   input  wire logic        s_axi_arready_out,
   input  wire logic [31:0] s_axi_rdata_out,
   input  wire logic [1:0]  s_axi_rresp_out,
   input  wire logic        s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Timer side outputs.
   input  wire logic        irq_out,
   input  wire logic        split_mode_out,
   input  wire logic [31:0] a_load_value_out,
   input  wire logic        a_counter_load_out,
   input  wire logic [15:0] b_load_value_out
);
   // One clock domain, so clocking and reset are given once.
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   // A read address is taken, and a write completes with its response.
   sequence ar_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   sequence wr_done;
      $rose(s_axi_bvalid_out);
   endsequence

   // Upper half follows the mode; B load and A lower half only move on a completed write, and irq only falls after one.
   AST_SPLIT_UPPER: assert property (split_mode_out |->
      a_load_value_out[31:16] == 16'h0000) else $error("upper not zero");
   AST_WIDE_UPPER: assert property (!split_mode_out |->
      a_load_value_out[31:16] == b_load_value_out) else $error("upper bad");
   AST_B_BY_WRITE: assert property ($changed(b_load_value_out)
      |-> wr_done) else $error("b load moved without a write");
   AST_LOW_BY_WRITE: assert property ($changed(a_load_value_out[15:0])
      |-> wr_done ##0 a_counter_load_out) else $error("lower moved alone");
   AST_PULSE: assert property (a_counter_load_out |->
      wr_done ##1 !a_counter_load_out) else $error("load pulse bad");
   AST_IRQ_FALL: assert property ($fell(irq_out) |->
      $past(s_axi_bvalid_out)) else $error("irq dropped without a write");
   // Bus answers hold until taken; a read answers next cycle, and readies stay low while bvalid.
   AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("b drop");
   AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)
      && $stable(s_axi_rresp_out)) else $error("r drop");
   AST_READ_LAT: assert property (ar_taken |=>
      s_axi_rvalid_out && !s_axi_arready_out) else $error("read late");
   AST_WR_BUSY: assert property (s_axi_bvalid_out |->
      !s_axi_awready_out && !s_axi_wready_out) else $error("ready early");
endmodule
`default_nettype wire

// ===== tb/test_timer_irq_load.sv
// Self-checking bench for the timer interrupt and interval load block.
`timescale 1ns/1ps
`default_nettype none
module test_timer_irq_load;
   // Design ports, named as on the block so the instance connects them.
   logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, a_load_value_out;
   logic [15:0] b_load_value_out;
   logic [6:0]  irq_event_in;
   logic [3:0]  s_axi_wstrb_in;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
   logic        clock_in, resetn_in, s_axi_awvalid_in, s_axi_awready_out;
   logic        s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
   logic        s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic        s_axi_rvalid_out, s_axi_rready_in, irq_out, split_mode_out;
   logic        a_counter_load_out;
   // Bench state: counters, seed and the expected register contents.
   int          n_errors, n_tests, n_pulses, seed, p;
   logic [31:0] raw, en, c, d, m;
   logic [15:0] lo, b_exp;
   logic [6:0]  ev;
   logic [3:0]  s;
   logic        split;

   timer_irq_load dut (.*);

   // Free-running 50 MHz clock.
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   // Load pulses are counted mid-cycle, away from the launching edge.
   always @(negedge clock_in) begin
      if (a_counter_load_out === 1'b1) n_pulses++;
   end

   // Byte strobes to a bit mask, and events to their status positions.
   function automatic logic [31:0] lanes(input logic [3:0] k);
      lanes = {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
   endfunction
   function automatic logic [31:0] spread(input logic [6:0] e);
      spread = {21'h0, e[6:4], 4'h0, e[3:0]};
   endfunction

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One write; ready is raised only after the response shows, so it stalls.
   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] k, input logic [1:0] er);
      logic ha, hw, hb, sv;
      logic [1:0] r;
      int n;
      @(posedge clock_in);
      s_axi_awaddr_in  <= a;
      s_axi_wdata_in   <= v;
      s_axi_wstrb_in   <= k;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in  <= 1'b1;
      hb = 1'b0;
      for (n = 0; n < 50 && !hb; n++) begin
         @(negedge clock_in);
         ha = s_axi_awvalid_in && s_axi_awready_out;
         hw = s_axi_wvalid_in && s_axi_wready_out;
         hb = s_axi_bvalid_out && s_axi_bready_in;
         sv = s_axi_bvalid_out;
         r = s_axi_bresp_out;
         @(posedge clock_in);
         if (ha) s_axi_awvalid_in <= 1'b0;
         if (hw) s_axi_wvalid_in <= 1'b0;
         if (sv) s_axi_bready_in <= !hb;
      end
      chk({31'h0, hb}, 32'h1);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // One read with a one-cycle stall on the data channel.
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic ha, hr, sv;
      logic [31:0] v;
      logic [1:0] r;
      int n;
      @(posedge clock_in);
      s_axi_araddr_in  <= a;
      s_axi_arvalid_in <= 1'b1;
      hr = 1'b0;
      for (n = 0; n < 50 && !hr; n++) begin
         @(negedge clock_in);
         ha = s_axi_arvalid_in && s_axi_arready_out;
         hr = s_axi_rvalid_out && s_axi_rready_in;
         sv = s_axi_rvalid_out;
         v = s_axi_rdata_out;
         r = s_axi_rresp_out;
         @(posedge clock_in);
         if (ha) s_axi_arvalid_in <= 1'b0;
         if (sv) s_axi_rready_in <= !hr;
      end
      chk({31'h0, hr}, 32'h1);
      chk(v, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // Checks the values every reset must leave behind.
   task automatic reset_check;
      raw = 32'h0;
      en = 32'h0;
      lo = 16'hffff;
      b_exp = 16'hffff;
      chk(a_load_value_out, 32'hffffffff);
      chk({16'h0, b_load_value_out}, 32'h0000ffff);
      chk({31'h0, irq_out}, 32'h0);
      rd(12'h028, 32'hffffffff, 2'h0);
      rd(12'h01c, 32'h0, 2'h0);
      rd(12'h024, 32'h0, 2'h0);
      $display("test reset done");
   endtask

   // Main sequence; a second reset at the end of the run rechecks the reset values.
   initial begin
      seed = 32'h13d29e88;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
      {s_axi_wstrb_in, s_axi_awvalid_in, s_axi_wvalid_in} = '0;
      {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
      irq_event_in = 7'h00;
      resetn_in = 1'b0;
      repeat (3) @(posedge clock_in);
      resetn_in <= 1'b1;
      reset_check();
      for (int i = 0; i < 12; i++) begin
         en = $random(seed);
         wr(12'h018, en, 4'hf, 2'h0);
         en &= 32'h0000070f;
         rd(12'h018, en, 2'h0);
         ev = (i < 2) ? 7'h7f : 7'($random(seed));
         @(posedge clock_in);
         irq_event_in <= ev;
         @(posedge clock_in);
         irq_event_in <= 7'h00;
         raw |= spread(ev);
         c = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
         s = (i < 2) ? 4'hf : 4'($random(seed));
         wr(12'h024, c, s, 2'h0);
         raw &= ~(c & lanes(s));
         rd(12'h01c, raw, 2'h0);
         rd(12'h020, raw & en, 2'h0);
         chk({31'h0, irq_out}, {31'h0, |(raw & en)});
      end
      wr(12'h01c, 32'hffffffff, 4'hf, 2'h0);
      rd(12'h01c, raw, 2'h0);
      wr(12'h100, 32'hffffffff, 4'hf, 2'h2);
      rd(12'h100, 32'h0, 2'h2);
      $display("test irq done");
      for (int i = 0; i < 16; i++) begin
         split = i[3];
         wr(12'h000, {31'h0, split}, 4'hf, 2'h0);
         d = $random(seed);
         s = (i[2:0] == 0) ? 4'hf : (i[2:0] == 1) ? 4'hc : 4'($random(seed));
         p = n_pulses;
         wr(12'h028, d, s, 2'h0);
         m = lanes(s);
         lo = (lo & ~m[15:0]) | (d[15:0] & m[15:0]);
         if (!split) b_exp = (b_exp & ~m[31:16]) | (d[31:16] & m[31:16]);
         rd(12'h028, {split ? 16'h0 : b_exp, lo}, 2'h0);
         rd(12'h02c, {16'h0, b_exp}, 2'h0);
         chk(a_load_value_out, {split ? 16'h0 : b_exp, lo});
         chk(32'(n_pulses - p), {31'h0, s[1:0] != 2'h0});
         chk({31'h0, split_mode_out}, {31'h0, split});
         rd(12'h000, {31'h0, split}, 2'h0);
         d = $random(seed);
         wr(12'h02c, d, 4'hf, 2'h0);
         if (split) b_exp = d[15:0];
         chk({16'h0, b_load_value_out}, {16'h0, b_exp});
         rd(12'h028, {split ? 16'h0 : b_exp, lo}, 2'h0);
      end
      $display("test load done");
      @(posedge clock_in);
      resetn_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      resetn_in <= 1'b1;
      reset_check();
      final_report();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge clock_in);
      n_errors++;
      final_report();
   end
endmodule

bind timer_irq_load timer_irq_load_assertions checker_i (.*);
`default_nettype wire
